// file: logic/iosq_consts.vh
// Constants for the I/O state query command interpreter
`ifndef IOSQ_CONSTS_VH
`define IOSQ_CONSTS_VH
`define IOSQ_CMD_MOD_IN 16'h7010
`define IOSQ_CMD_OUT 16'h7020
`define IOSQ_CMD_TERM 16'h8010
`define IOSQ_CMD_TERM_ALL 16'h8020
`define IOSQ_SUB_CODE 16'h0020
`define IOSQ_RESULT_OK 32'h00000000
`define IOSQ_RESULT_FAIL 32'hFFFFFFFF
`define IOSQ_MOD_COUNT 32'h00000005
`define IOSQ_CLASS_TRIG 32'h00000000
`define IOSQ_CLASS_REQ 32'h00000001
`define IOSQ_CLASS_DATA 32'h00000002
`define IOSQ_DATA_TERMS 32'h00000008
`define IOSQ_CTRL_TERMS 32'h00000002
`define IOSQ_BIT_TRIG0 0
`define IOSQ_BIT_REQ0 1
`define IOSQ_BIT_TRIG1 2
`define IOSQ_BIT_REQ1 3
`endif

// file: logic/iosq_query.v
// I/O state query command interpreter
`timescale 1ns/100ps
// Summary of operation
// - 7010 reports selected module input permission
// - Module input answer: 0 forbidden, 1 allowed
// - 7020 without parameters reports output permission
// - Output answer: 0 forbidden, 1 allowed
// - 8010 returns one chosen terminal state
// - Terminal answer: 1 on, 0 off
// - 8020 returns all non-data terminals packed
// - Bits: trig0, req0, trig1, req1
// - Echo command code and second command word as received
// - Result word zero success, all ones failure
`include "iosq_consts.vh"
module iosq_query (
  input wire sys_clk_in,
  input wire srst_in,
  input wire cmd_valid_in,
  input wire [15:0] cmd_code_in,
  input wire [15:0] cmd_sub_in,
  input wire [31:0] cmd_param0_in,
  input wire [31:0] cmd_param1_in,
  input wire [4:0] mod_input_allowed_in,
  input wire output_allowed_in,
  input wire [1:0] trigger_input_in,
  input wire [1:0] output_request_input_in,
  input wire [7:0] command_data_input_in,
  output reg rsp_valid_out,
  output reg [15:0] rsp_code_out,
  output reg [15:0] rsp_sub_out,
  output reg [31:0] rsp_result_out,
  output reg [31:0] rsp_data_out
);

  reg ok;
  reg [31:0] data;

  // Selected terminal state, with range check
  function [1:0] term_pick;
    input [31:0] cls;
    input [31:0] idx;
    input [1:0] trig;
    input [1:0] req;
    input [7:0] din;
    begin
      term_pick = 2'b00;
      if (cls == `IOSQ_CLASS_TRIG)
      begin
        if (idx < `IOSQ_CTRL_TERMS)
          term_pick = {1'b1, trig[idx[0]]};
      end
      else if (cls == `IOSQ_CLASS_REQ)
      begin
        if (idx < `IOSQ_CTRL_TERMS)
          term_pick = {1'b1, req[idx[0]]};
      end
      else if (cls == `IOSQ_CLASS_DATA)
      begin
        if (idx < `IOSQ_DATA_TERMS)
          term_pick = {1'b1, din[idx[2:0]]};
      end
    end
  endfunction

  wire [1:0] pick;
  wire [1:0] mod_sel;

  // Widen a single answer bit to a data word
  function [31:0] bit_word;
    input b;
    begin
      bit_word = {31'h0, b};
    end
  endfunction

  // Exact match of a command word
  function code_match;
    input [15:0] word;
    input [15:0] code;
    begin
      code_match = (word == code);
    end
  endfunction

  // Result word from the success flag
  function [31:0] result_word;
    input good;
    begin
      if (good)
        result_word = `IOSQ_RESULT_OK;
      else
        result_word = `IOSQ_RESULT_FAIL;
    end
  endfunction

  // Selected module permission, with range check
  function [1:0] mod_pick;
    input [31:0] sel;
    input [4:0] allowed;
    begin
      mod_pick = 2'b00;
      if (sel < `IOSQ_MOD_COUNT)
      begin
        mod_pick = {1'b1, allowed[sel[2:0]]};
      end
    end
  endfunction

  // Non-data terminals packed into one word
  function [31:0] pack_ctrl;
    input [1:0] trig;
    input [1:0] req;
    begin
      pack_ctrl = 32'h00000000;
      pack_ctrl[`IOSQ_BIT_TRIG0] = trig[0];
      pack_ctrl[`IOSQ_BIT_REQ0] = req[0];
      pack_ctrl[`IOSQ_BIT_TRIG1] = trig[1];
      pack_ctrl[`IOSQ_BIT_REQ1] = req[1];
    end
  endfunction

  // Command decode flags
  wire sub_match;
  wire is_mod_in;
  wire is_out;
  wire is_term;
  wire is_term_all;
  wire take;

  assign sub_match = code_match(cmd_sub_in, `IOSQ_SUB_CODE);
  assign is_mod_in = code_match(cmd_code_in, `IOSQ_CMD_MOD_IN);
  assign is_out = code_match(cmd_code_in, `IOSQ_CMD_OUT);
  assign is_term = code_match(cmd_code_in, `IOSQ_CMD_TERM);
  assign is_term_all = code_match(cmd_code_in, `IOSQ_CMD_TERM_ALL);
  assign take = cmd_valid_in;

  // Parameter lookups, each with its own range check
  assign mod_sel = mod_pick(cmd_param0_in, mod_input_allowed_in);
  assign pick = term_pick(cmd_param0_in, cmd_param1_in, trigger_input_in,
    output_request_input_in, command_data_input_in);

  // Success flag for the current command
  always @*
  begin
    ok = 1'b0;
    if (!sub_match)
    begin
      ok = 1'b0;
    end
    else if (is_mod_in)
    begin
      ok = mod_sel[1];
    end
    else if (is_out)
    begin
      ok = 1'b1;
    end
    else if (is_term)
    begin
      ok = pick[1];
    end
    else if (is_term_all)
    begin
      ok = 1'b1;
    end
    else
    begin
      ok = 1'b0;
    end
  end

  // Answer word for the current command, zero when it fails
  always @*
  begin
    data = 32'h00000000;
    if (!sub_match)
    begin
      data = 32'h00000000;
    end
    else if (is_mod_in)
    begin
      data = bit_word(mod_sel[1] & mod_sel[0]);
    end
    else if (is_out)
    begin
      data = bit_word(output_allowed_in);
    end
    else if (is_term)
    begin
      data = bit_word(pick[1] & pick[0]);
    end
    else if (is_term_all)
    begin
      data = pack_ctrl(trigger_input_in, output_request_input_in);
    end
    else
    begin
      data = 32'h00000000;
    end
  end

  // Next response values; echo fields hold between commands
  reg next_valid;
  reg [15:0] next_code;
  reg [15:0] next_sub;
  reg [31:0] next_result;
  reg [31:0] next_data;

  always @*
  begin
    next_valid = take;
    next_code = rsp_code_out;
    next_sub = rsp_sub_out;
    next_result = rsp_result_out;
    next_data = rsp_data_out;
    if (take)
    begin
      next_code = cmd_code_in;
      next_sub = cmd_sub_in;
      next_result = result_word(ok);
      if (ok)
      begin
        next_data = data;
      end
      else
      begin
        next_data = 32'h00000000;
      end
    end
  end

  // Response strobe, one cycle per taken command
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rsp_valid_out <= 1'b0;
    end
    else
    begin
      rsp_valid_out <= next_valid;
    end
  end

  // Echoed command code
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rsp_code_out <= 16'h0000;
    end
    else
    begin
      rsp_code_out <= next_code;
    end
  end

  // Echoed second command word
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rsp_sub_out <= 16'h0000;
    end
    else
    begin
      rsp_sub_out <= next_sub;
    end
  end

  // Execution result word
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rsp_result_out <= 32'h00000000;
    end
    else
    begin
      rsp_result_out <= next_result;
    end
  end

  // Answer data word
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rsp_data_out <= 32'h00000000;
    end
    else
    begin
      rsp_data_out <= next_data;
    end
  end

endmodule // iosq_query

// file: verif/iosq_query_asserts.sv
// Assertion checker for the query block
`timescale 1ns/100ps
module iosq_chk(input wire sys_clk_in,srst_in,cmd_valid_in,rsp_valid_out,output_allowed_in,
 input wire [15:0] cmd_code_in,cmd_sub_in,rsp_code_out,rsp_sub_out,input wire [31:0] rsp_result_out,rsp_data_out,
 input wire [1:0] trigger_input_in,output_request_input_in);
default clocking @(posedge sys_clk_in); endclocking
default disable iff (srst_in);
wire [3:0] pk={output_request_input_in[1],trigger_input_in[1],output_request_input_in[0],trigger_input_in[0]};
property p_rsp;cmd_valid_in|=>rsp_valid_out&&rsp_code_out==$past(cmd_code_in);endproperty
a_rsp:assert property(p_rsp)else $error("echo");
property p_idle;!cmd_valid_in|=>!rsp_valid_out;endproperty
a_idle:assert property(p_idle)else $error("stray");
property p_all;cmd_valid_in&&cmd_code_in==16'h8020&&cmd_sub_in==16'h0020|=>rsp_data_out==$past(pk);endproperty
a_all:assert property(p_all)else $error("pack");
property p_bad;cmd_valid_in&&cmd_sub_in!=16'h0020|=>rsp_result_out==32'hFFFFFFFF&&rsp_data_out==32'h0;endproperty
a_bad:assert property(p_bad)else $error("fail");
property p_sub;cmd_valid_in|=>rsp_sub_out==$past(cmd_sub_in);endproperty
a_sub:assert property(p_sub)else $error("sub echo");
property p_out;cmd_valid_in&&cmd_code_in==16'h7020&&cmd_sub_in==16'h0020|=>
 rsp_result_out==32'h0&&rsp_data_out=={31'h0,$past(output_allowed_in)};endproperty
a_out:assert property(p_out)else $error("output state");
property p_hold;!cmd_valid_in|=>$stable(rsp_code_out)&&$stable(rsp_result_out)&&$stable(rsp_data_out);endproperty
a_hold:assert property(p_hold)else $error("hold");
endmodule // iosq_chk
bind iosq_query iosq_chk i_chk(.*);

// file: verif/iosq_plc.sv
// Controller model issuing query commands
`timescale 1ns/100ps
module iosq_plc(input wire clk_in,output reg v_out=0,output reg [15:0] c_out=0,s_out=0,
 output reg [31:0] a_out=0,b_out=0);
task send(input [15:0] c,s,input [31:0] a,b);
begin
@(posedge clk_in) #1 {v_out,c_out,s_out,a_out,b_out}={1'b1,c,s,a,b};
@(posedge clk_in) #1 {v_out,c_out,s_out,a_out,b_out}={1'b0,~c,~s,~a,~b};
end
endtask
endmodule // iosq_plc

// file: verif/iosq_query_bench.sv
// Self-checking bench for the query block
`timescale 1ns/100ps
module iosq_query_bench;
reg clk=0,rst=1,oa=0;
reg [4:0] mi=0;
reg [1:0] tr=0,rq=0;
reg [7:0] di=0;
reg [15:0] cd[0:4]='{16'h7010,16'h7020,16'h8010,16'h8020,16'h8030};
wire v,rv;
wire [15:0] c,s,rc,rs;
wire [31:0] a,b,rr,rd;
integer mismatches=0,n_compared=0,cyc=0,i;
always #2.5 clk=~clk;
iosq_plc i_plc(.clk_in(clk),.v_out(v),.c_out(c),.s_out(s),.a_out(a),.b_out(b));
iosq_query i_dut(.sys_clk_in(clk),.srst_in(rst),.cmd_valid_in(v),.cmd_code_in(c),.cmd_sub_in(s),
 .cmd_param0_in(a),.cmd_param1_in(b),.mod_input_allowed_in(mi),.output_allowed_in(oa),.trigger_input_in(tr),
 .output_request_input_in(rq),.command_data_input_in(di),.rsp_valid_out(rv),.rsp_code_out(rc),
 .rsp_sub_out(rs),.rsp_result_out(rr),.rsp_data_out(rd));
function [63:0] ex(input [15:0] c,s,input [31:0] a,b);
reg ok;
reg [31:0] d;
begin
ok=s==16'h0020;
d=32'h0;
case(c)
16'h7010: begin ok&=a<5; d=mi[a]; end
16'h7020: d=oa;
16'h8010: begin ok&=a<3&&b<(a==2?8:2); d=a==0?tr[b]:a==1?rq[b]:di[b]; end
16'h8020: d={rq[1],tr[1],rq[0],tr[0]};
default: ok=0;
endcase
ex={ok?32'h0:32'hFFFFFFFF,ok?d:32'h0};
end
endfunction
task chk(input [96:0] seen,exp);
begin
n_compared++;
if(seen!==exp) begin mismatches++; $display("BAD rsp exp %h seen %h",exp,seen); end
end
endtask
task run(input [15:0] cc,ss,input [31:0] pa,pb);
reg [63:0] e;
begin
{mi,oa,tr,rq,di}=$urandom;
e=ex(cc,ss,pa,pb);
i_plc.send(cc,ss,pa,pb);
chk({rv,rc,rs,rr,rd},{1'b1,cc,ss,e});
end
endtask
task results;
begin
$display("compared %0d mismatches %0d",n_compared,mismatches);
if(mismatches==0&&n_compared>0) $display("DONE - PASS");
else $display("DONE - FAIL");
$finish;
end
endtask
always @(posedge clk) if(++cyc>3000) begin mismatches++; results; end
initial
begin
i=$urandom(39);
repeat(8) @(posedge clk);
#1 rst=0;
run(16'h8010,16'h0020,2,7);
run(16'h8010,16'h0020,2,8);
run(16'h8010,16'h0020,1,2);
run(16'h7010,16'h0020,5,0);
run(16'h7020,16'h0021,0,0);
$display("corner test done");
for(i=0;i<400;i++) run(cd[$urandom%5],$urandom%6?16'h0020:16'h0021,$urandom%6,$urandom%9);
$display("random test done");
results;
end
endmodule // iosq_query_bench
